// >>> hdl/gpm_defines.svh
// Offsets, field positions and reset values of the GPIO port registers.
// Assumes inclusion by bare name from the hdl folder.
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define GPM_OFS_DIRECTION   4'hA
`define GPM_OFS_PIN_LEVEL   4'hB
`define GPM_OFS_IRQ_ENABLE  4'hC
`define GPM_OFS_CONTROL     4'hE

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPM_RST_DIRECTION   8'h00
`define GPM_RST_PIN_LEVEL   8'hFF
`define GPM_RST_IRQ_ENABLE  8'h00
`define GPM_RST_CONTROL     8'h00
`define GPM_RD_UNMAPPED     8'h00

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define GPM_CTL_LATCH       0
`define GPM_CTL_MODEM_HI    1
`define GPM_CTL_MODEM_LO    2
`define GPM_CTL_SOFT_RESET  3
`define GPM_CTL_RW_MASK     8'h07

// ----------------------------------------------------------------------
// Modem pin positions, upper nibble first channel, lower second
// ----------------------------------------------------------------------
`define GPM_PIN_RI_HI       7
`define GPM_PIN_CD_HI       6
`define GPM_PIN_DTR_HI      5
`define GPM_PIN_DSR_HI      4
`define GPM_PIN_RI_LO       3
`define GPM_PIN_CD_LO       2
`define GPM_PIN_DTR_LO      1
`define GPM_PIN_DSR_LO      0

`endif

// >>> hdl/gpm_pkg.sv
// Types shared by the GPIO port modules.
// Assumes the defines header holds all numeric constants.
package gpm_pkg;
    typedef logic [7:0] gpm_byte_t;
    typedef logic [3:0] gpm_addr_t;
endpackage

// >>> hdl/gpm_chg_if.sv
// Carrier between the port top and its change detector.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
interface gpm_chg_if #(parameter int W = 8);
    logic [W-1:0] pin;
    logic [W-1:0] arm;
    logic         latch;
    logic         capture;
    logic         srst;
    logic [W-1:0] pend;
    logic [W-1:0] held;

    modport ctl (output pin, arm, latch, capture, srst, input pend, held);
    modport det (input pin, arm, latch, capture, srst, output pend, held);
endinterface

// >>> hdl/gpm_chg.sv
// Per-pin change detector with reference levels and optional latching.
// Assumes pin levels synchronous to MCLK.
`timescale 1ns/100ps
module gpm_chg #(
    parameter int W = 8
) (
    input  wire logic MCLK,
    input  wire logic ARST_N,
    gpm_chg_if.det    chg
);
    logic [W-1:0] ref_q,  ref_d;
    logic [W-1:0] prev_q;
    logic [W-1:0] stk_q,  stk_d;
    logic [W-1:0] held_q, held_d;
    wire  [W-1:0] mism  = chg.arm & (chg.pin ^ ref_q);
    wire  [W-1:0] event_w = mism & (chg.pin ^ prev_q);
    // An event refreshes the held level unless an older one is still pending
    wire  [W-1:0] fresh_w = event_w & ~(stk_q & ~{W{chg.capture}});

    // ------------------------------------------------------------------
    // Reference and sticky state
    // ------------------------------------------------------------------
    assign ref_d  = chg.capture ? chg.pin : ref_q;
    // Set wins over the clear of a read
    assign stk_d  = chg.latch ? ((stk_q & ~{W{chg.capture}}) | event_w)
                              : '0;
    assign held_d = (fresh_w & chg.pin) | (held_q & ~fresh_w);
    assign chg.pend = chg.latch ? stk_q : mism;
    assign chg.held = held_q;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ref_q  <= '0;
            prev_q <= '0;
            stk_q  <= '0;
            held_q <= '0;
        end else if (chg.srst) begin
            ref_q  <= '0;
            prev_q <= chg.pin;
            stk_q  <= '0;
            held_q <= '0;
        end else begin
            ref_q  <= ref_d;
            prev_q <= chg.pin;
            stk_q  <= stk_d;
            held_q <= held_d;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    latch_keep_a: assert property (chg.latch && stk_q != 0 && !chg.capture
        && !chg.srst |=> (stk_q & $past(stk_q)) == $past(stk_q))
        else $error("latched change lost before read");
    capture_ref_a: assert property (chg.capture && !chg.srst |=> ref_q == $past(chg.pin))
        else $error("reference not captured on read");
endmodule

// >>> hdl/gpm_port.sv
// GPIO port with per-nibble modem select, one select bit for each of the two channels.
// Assumes a register strobe port from the host bridge and pins sampled on MCLK.
`timescale 1ns/100ps
`include "gpm_defines.svh"
module gpm_port #(
    parameter int W = 8
) (
    input  wire logic       MCLK,
    input  wire logic       ARST_N,
    input  wire logic [3:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output      logic [7:0] REG_RDATA,
    input  wire logic [7:0] GPIO_IN,
    output      logic [7:0] GPIO_OUT,
    output      logic [7:0] GPIO_OE,
    output      logic       GPIO_IRQ,
    output      logic       SOFT_RESET,
    input  wire logic       TERM_READY_FIRST_N,
    input  wire logic       TERM_READY_SECOND_N,
    output      logic       RING_IND_FIRST_N,
    output      logic       CARRIER_DET_FIRST_N,
    output      logic       SET_READY_FIRST_N,
    output      logic       RING_IND_SECOND_N,
    output      logic       CARRIER_DET_SECOND_N,
    output      logic       SET_READY_SECOND_N
);
    gpm_pkg::gpm_byte_t dir_q, dir_d;
    gpm_pkg::gpm_byte_t lvl_q, lvl_d;
    gpm_pkg::gpm_byte_t ien_q, ien_d;
    gpm_pkg::gpm_byte_t ctl_q, ctl_d;
    gpm_pkg::gpm_byte_t rdata_d;
    gpm_pkg::gpm_byte_t out_d, oe_d;
    logic               srst_q;

    gpm_chg_if #(.W(W)) chg ();

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire sel_dir  = (REG_ADDR == `GPM_OFS_DIRECTION);
    wire sel_lvl  = (REG_ADDR == `GPM_OFS_PIN_LEVEL);
    wire sel_ien  = (REG_ADDR == `GPM_OFS_IRQ_ENABLE);
    wire sel_ctl  = (REG_ADDR == `GPM_OFS_CONTROL);
    wire wr_dir   = REG_WR & sel_dir;
    wire wr_lvl   = REG_WR & sel_lvl;
    wire wr_ien   = REG_WR & sel_ien;
    wire wr_ctl   = REG_WR & sel_ctl;
    wire rd_lvl   = REG_RD & sel_lvl;

    // ------------------------------------------------------------------
    // Nibble modes
    // ------------------------------------------------------------------
    wire modem_hi = ctl_q[`GPM_CTL_MODEM_HI];
    wire modem_lo = ctl_q[`GPM_CTL_MODEM_LO];
    wire latch_on = ctl_q[`GPM_CTL_LATCH];
    wire [7:0] gpio_sel = {{4{~modem_hi}}, {4{~modem_lo}}};
    wire [7:0] drv_gpio = gpio_sel & dir_q;
    wire [7:0] arm_w    = ien_q & gpio_sel & ~dir_q;

    // ------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------
    assign dir_d = wr_dir ? REG_WDATA : dir_q;
    assign lvl_d = wr_lvl ? REG_WDATA : lvl_q;
    assign ien_d = wr_ien ? REG_WDATA : ien_q;
    assign ctl_d = wr_ctl ? (REG_WDATA & `GPM_CTL_RW_MASK) : ctl_q;
    wire   srst_req = wr_ctl & REG_WDATA[`GPM_CTL_SOFT_RESET];

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [7:0] held_sel  = latch_on ? chg.pend : 8'h00;
    wire [7:0] lvl_view  = (held_sel & chg.held) | (~held_sel & GPIO_IN);
    wire [7:0] ctl_view  = {4'h0, srst_q, ctl_q[2:0]};
    assign rdata_d = sel_dir ? dir_q :
                     sel_lvl ? lvl_view :
                     sel_ien ? ien_q :
                     sel_ctl ? ctl_view : `GPM_RD_UNMAPPED;

    // ------------------------------------------------------------------
    // Pin drive, modem terminal ready passes out in modem mode
    // ------------------------------------------------------------------
    always_comb begin
        out_d = lvl_q;
        oe_d  = drv_gpio;
        if (modem_hi) begin
            out_d[`GPM_PIN_DTR_HI] = TERM_READY_FIRST_N;
            oe_d[`GPM_PIN_DTR_HI]  = 1'b1;
        end
        if (modem_lo) begin
            out_d[`GPM_PIN_DTR_LO] = TERM_READY_SECOND_N;
            oe_d[`GPM_PIN_DTR_LO]  = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Change detector
    // ------------------------------------------------------------------
    assign chg.pin     = GPIO_IN;
    assign chg.arm     = arm_w;
    assign chg.latch   = latch_on;
    assign chg.capture = rd_lvl;
    assign chg.srst    = srst_q;

    gpm_chg #(.W(W)) u_chg (
        .MCLK   (MCLK),
        .ARST_N (ARST_N),
        .chg    (chg)
    );

    // ------------------------------------------------------------------
    // Registers; soft reset clears the single shared set
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dir_q  <= `GPM_RST_DIRECTION;
            lvl_q  <= `GPM_RST_PIN_LEVEL;
            ien_q  <= `GPM_RST_IRQ_ENABLE;
            ctl_q  <= `GPM_RST_CONTROL;
            srst_q <= 1'b0;
        end else if (srst_q) begin
            dir_q  <= `GPM_RST_DIRECTION;
            lvl_q  <= `GPM_RST_PIN_LEVEL;
            ien_q  <= `GPM_RST_IRQ_ENABLE;
            ctl_q  <= `GPM_RST_CONTROL;
            srst_q <= 1'b0;
        end else begin
            dir_q  <= dir_d;
            lvl_q  <= lvl_d;
            ien_q  <= ien_d;
            ctl_q  <= ctl_d;
            srst_q <= srst_req;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= `GPM_RD_UNMAPPED;
            GPIO_OUT  <= `GPM_RST_PIN_LEVEL;
            GPIO_OE   <= `GPM_RST_DIRECTION;
            GPIO_IRQ  <= 1'b0;
            SOFT_RESET <= 1'b0;
        end else begin
            REG_RDATA <= REG_RD ? rdata_d : REG_RDATA;
            GPIO_OUT  <= out_d;
            GPIO_OE   <= oe_d;
            GPIO_IRQ  <= |chg.pend;
            SOFT_RESET <= srst_q;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RING_IND_FIRST_N     <= 1'b1;
            CARRIER_DET_FIRST_N  <= 1'b1;
            SET_READY_FIRST_N    <= 1'b1;
            RING_IND_SECOND_N    <= 1'b1;
            CARRIER_DET_SECOND_N <= 1'b1;
            SET_READY_SECOND_N   <= 1'b1;
        end else begin
            RING_IND_FIRST_N     <= modem_hi ? GPIO_IN[`GPM_PIN_RI_HI]  : 1'b1;
            CARRIER_DET_FIRST_N  <= modem_hi ? GPIO_IN[`GPM_PIN_CD_HI]  : 1'b1;
            SET_READY_FIRST_N    <= modem_hi ? GPIO_IN[`GPM_PIN_DSR_HI] : 1'b1;
            RING_IND_SECOND_N    <= modem_lo ? GPIO_IN[`GPM_PIN_RI_LO]  : 1'b1;
            CARRIER_DET_SECOND_N <= modem_lo ? GPIO_IN[`GPM_PIN_CD_LO]  : 1'b1;
            SET_READY_SECOND_N   <= modem_lo ? GPIO_IN[`GPM_PIN_DSR_LO] : 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    sequence soft_rst_req_s;
        wr_ctl && REG_WDATA[`GPM_CTL_SOFT_RESET] && !srst_q;
    endsequence
    sequence soft_rst_done_s;
        srst_q ##1 (!srst_q && ctl_q == `GPM_RST_CONTROL);
    endsequence

    read_level_a: assert property (rd_lvl && !latch_on |=> REG_RDATA == $past(GPIO_IN))
        else $error("pin level read does not match pins");
    pin_drive_a: assert property (##1 ((GPIO_OUT ^ $past(lvl_q))
        & $past(drv_gpio)) == 8'h00)
        else $error("output pin differs from written level");
    level_reset_a: assert property (srst_q |=> lvl_q == `GPM_RST_PIN_LEVEL
        && ien_q == `GPM_RST_IRQ_ENABLE)
        else $error("soft reset left level or enable unset");
    modem_mask_a: assert property (modem_hi |-> arm_w[7:4] == 4'h0)
        else $error("modem nibble still armed");
    soft_clear_a: assert property (soft_rst_req_s |=> soft_rst_done_s ##1 !SOFT_RESET)
        else $error("soft reset bit did not clear itself");
    modem_lo_a: assert property (modem_lo |=>
        RING_IND_SECOND_N == $past(GPIO_IN[`GPM_PIN_RI_LO]))
        else $error("second channel ring indicate not passed");
    modem_dtr_a: assert property (modem_hi |=> GPIO_OE[`GPM_PIN_DTR_HI]
        && GPIO_OUT[`GPM_PIN_DTR_HI] == $past(TERM_READY_FIRST_N))
        else $error("first channel terminal ready not driven");
    unlatched_drop_a: assert property (!latch_on && chg.pend == 8'h00 |=> !GPIO_IRQ)
        else $error("interrupt kept after input returned");
    // Pending bits survive a cycle with no read, so the interrupt follows
    latched_hold_a: assert property (latch_on && chg.pend != 8'h00 && !rd_lvl
        && !srst_q |=> ##1 GPIO_IRQ)
        else $error("latched interrupt dropped without read");
    dir_default_a: assert property (srst_q |=> dir_q == `GPM_RST_DIRECTION
        ##1 GPIO_OE == `GPM_RST_DIRECTION)
        else $error("pins not inputs after reset");
endmodule

// >>> tb/gpm_pins.sv
// Pin model on the far side of the GPIO port.
// Assumes the bench sets the external levels and the port drives when enabled.
`timescale 1ns/100ps
module gpm_pins (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_level,
    output      logic [7:0] pin_in
);
    // --------------------------------------------------------------
    // Pad resolution
    // --------------------------------------------------------------
    // Driven bits show the port's value, the rest the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> tb/gpm_port_tb.sv
// Self-checking bench for the GPIO port with modem select.
// Assumes the defines header and the pin model are compiled alongside.
`timescale 1ns/100ps
`include "gpm_defines.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module gpm_port_tb;
    logic       mclk;
    logic       arst_n;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] gpio_in;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;
    logic [7:0] ext;
    logic       irq;
    logic       soft_reset;
    logic       tr1_n;
    logic       tr2_n;
    logic [5:0] mdm;
    logic [3:0] sr_seen = 4'h0;
    int         err_total;
    int         checks;

    // --------------------------------------------------------------
    // Clock, instances
    // --------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    gpm_port #(.W(8)) u_dut (
        .MCLK                 (mclk),
        .ARST_N               (arst_n),
        .REG_ADDR             (reg_addr),
        .REG_WDATA            (reg_wdata),
        .REG_WR               (reg_wr),
        .REG_RD               (reg_rd),
        .REG_RDATA            (reg_rdata),
        .GPIO_IN              (gpio_in),
        .GPIO_OUT             (gpio_out),
        .GPIO_OE              (gpio_oe),
        .GPIO_IRQ             (irq),
        .SOFT_RESET           (soft_reset),
        .TERM_READY_FIRST_N   (tr1_n),
        .TERM_READY_SECOND_N  (tr2_n),
        .RING_IND_FIRST_N     (mdm[5]),
        .CARRIER_DET_FIRST_N  (mdm[4]),
        .SET_READY_FIRST_N    (mdm[3]),
        .RING_IND_SECOND_N    (mdm[2]),
        .CARRIER_DET_SECOND_N (mdm[1]),
        .SET_READY_SECOND_N   (mdm[0])
    );

    gpm_pins u_pins (
        .pin_out   (gpio_out),
        .pin_oe    (gpio_oe),
        .ext_level (ext),
        .pin_in    (gpio_in)
    );

    always @(posedge mclk) begin
        if (soft_reset === 1'b1) sr_seen <= sr_seen + 4'h1;
    end

    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask

    task automatic chkr(input logic [3:0] a, input logic [7:0] ex, input string nm);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        cyc(1);
        `CHK(nm, ex, reg_rdata)
    endtask

    task automatic print_verdict;
        if (err_total == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        err_total++;
        print_verdict();
    end

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {arst_n, tr1_n, tr2_n, err_total, checks} = '0;
        ext = 8'h3C;
        repeat (12) @(posedge mclk);
        #1 arst_n = 1'b1;
        cyc(1);
        `CHK("out_rst", `GPM_RST_PIN_LEVEL, gpio_out)
        `CHK("oe_rst", 8'h00, gpio_oe)
        chkr(`GPM_OFS_IRQ_ENABLE, `GPM_RST_IRQ_ENABLE, "en_rst");
        chkr(`GPM_OFS_DIRECTION, `GPM_RST_DIRECTION, "dir_rst");
        chkr(`GPM_OFS_CONTROL, `GPM_RST_CONTROL, "ctl_rst");
        chkr(`GPM_OFS_PIN_LEVEL, 8'h3C, "lvl_in");
        wr(4'h5, 8'hFF);
        chkr(4'h5, `GPM_RD_UNMAPPED, "unmapped");
        // Outputs and mixed directions
        wr(`GPM_OFS_DIRECTION, 8'hFF);
        wr(`GPM_OFS_PIN_LEVEL, 8'h55);
        cyc(2);
        `CHK("out_55", 8'h55, gpio_out)
        `CHK("oe_all", 8'hFF, gpio_oe)
        ext = 8'hA0;
        wr(`GPM_OFS_DIRECTION, 8'h0F);
        cyc(2);
        chkr(`GPM_OFS_PIN_LEVEL, 8'hA5, "lvl_mix");
        // Modem select on both nibbles
        wr(`GPM_OFS_DIRECTION, 8'h00);
        ext = 8'hB4;
        tr2_n = 1'b1;
        wr(`GPM_OFS_CONTROL, 8'hF6);
        chkr(`GPM_OFS_CONTROL, 8'h06, "ctl_rsvd");
        cyc(3);
        `CHK("mdm_first", 3'b101, mdm[5:3])
        `CHK("mdm_second", 3'b010, mdm[2:0])
        `CHK("dtr_first", 1'b0, gpio_out[5])
        `CHK("dtr_second", 1'b1, gpio_out[1])
        wr(`GPM_OFS_IRQ_ENABLE, 8'hFF);
        chkr(`GPM_OFS_IRQ_ENABLE, 8'hFF, "en_rw");
        ext = 8'h4B;
        cyc(3);
        `CHK("irq_modem", 1'b0, irq)
        // Unlatched change interrupt
        ext = 8'h00;
        wr(`GPM_OFS_IRQ_ENABLE, 8'h01);
        wr(`GPM_OFS_CONTROL, 8'h00);
        chkr(`GPM_OFS_PIN_LEVEL, 8'h00, "lvl_ref");
        ext = 8'h01;
        cyc(3);
        `CHK("irq_set", 1'b1, irq)
        ext = 8'h00;
        cyc(3);
        `CHK("irq_back", 1'b0, irq)
        ext = 8'h02;
        cyc(3);
        `CHK("irq_dis", 1'b0, irq)
        // Latched change interrupt
        ext = 8'h00;
        wr(`GPM_OFS_CONTROL, 8'h01);
        chkr(`GPM_OFS_PIN_LEVEL, 8'h00, "lvl_ref2");
        ext = 8'h01;
        cyc(1);
        ext = 8'h00;
        cyc(3);
        `CHK("irq_latch", 1'b1, irq)
        chkr(`GPM_OFS_PIN_LEVEL, 8'h01, "lvl_held");
        cyc(2);
        `CHK("irq_clr", 1'b0, irq)
        // Soft reset of the whole register set
        wr(`GPM_OFS_DIRECTION, 8'hFF);
        wr(`GPM_OFS_PIN_LEVEL, 8'h00);
        cyc(2);
        `CHK("out_00", 8'h00, gpio_out)
        wr(`GPM_OFS_CONTROL, 8'h08);
        cyc(3);
        `CHK("sr_pulse", 4'h1, sr_seen)
        `CHK("out_sr", `GPM_RST_PIN_LEVEL, gpio_out)
        chkr(`GPM_OFS_DIRECTION, `GPM_RST_DIRECTION, "dir_sr");
        chkr(`GPM_OFS_IRQ_ENABLE, `GPM_RST_IRQ_ENABLE, "en_sr");
        chkr(`GPM_OFS_CONTROL, `GPM_RST_CONTROL, "ctl_sr");
        print_verdict();
    end
endmodule
